// ==== rtl/ctd_consts.svh ====
// constants for the clipper thread descriptor decoder
`ifndef CTD_CONSTS_SVH
`define CTD_CONSTS_SVH
`define CTD_KSP_HI          31
`define CTD_KSP_LO          6
`define CTD_BLK_HI          3
`define CTD_BLK_LO          1
`define CTD_REGS_PER_BLOCK  16
`define CTD_W0_MBZ_MASK     32'h0000_0031
`define CTD_W1_MBZ_MASK     32'h7C00_D000
`define CTD_FLOW_BIT        31
`define CTD_BTC_HI          25
`define CTD_BTC_LO          18
`define CTD_PRIO_BIT        17
`define CTD_FPM_BIT         16
`define CTD_ILLOP_BIT       13
`define CTD_MSTK_BIT        11
`define CTD_CR_ILLOP_BIT    12
`define CTD_CR_MSTK_BIT     11
`define CTD_WORD_BYTES      32'h0000_0004
`define CTD_HEAP_LIMIT_BIT  32
`endif

// ==== rtl/ctd_pkg.sv ====
// types shared by both ends of the clipper thread descriptor link
package ctd_pkg;
  typedef enum logic
  {
    CTD_FP_IEEE,
    CTD_FP_ALT
  } ctd_fp_mode_t;

  typedef struct packed
  {
    logic [25:0]  kernelOffset;
    logic [2:0]   blocksMinusOne;
    logic         singleFlow;
    logic [7:0]   bindingCount;
    logic         highPriority;
    ctd_fp_mode_t fpMode;
    logic         illegalOpEn;
    logic         maskStackEn;
  } ctd_desc_t;
endpackage

// ==== rtl/ctd_link_if.sv ====
// memory read link between the descriptor fetcher and the record store
`timescale 1ns/1ps
interface ctd_link_if;
  logic        rdReq;
  logic [31:0] rdAddr;
  logic        rdAck;
  logic [31:0] rdData;

  modport fetcher
  (
    output rdReq,
    output rdAddr,
    input  rdAck,
    input  rdData
  );
  modport store
  (
    input  rdReq,
    input  rdAddr,
    output rdAck,
    output rdData
  );
endinterface

// ==== rtl/ctd_record_store.sv ====
// software side: holds the two record words and answers reads
`timescale 1ns/1ps
`include "ctd_consts.svh"
module ctd_record_store
  import ctd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  ctd_link_if.store        link,
  input  wire logic        wrEn,
  input  wire logic [31:0] wrAddr,
  input  wire logic [31:0] wrData,
  output logic             wrRejected
);
  logic [31:0] word0_r, word0_nxt;
  logic [31:0] word1_r, word1_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] data_r, data_nxt;
  logic        rej_r, rej_nxt;
  logic [31:0] base_r, base_nxt;

  always_comb
  begin
    word0_nxt = word0_r;
    word1_nxt = word1_r;
    base_nxt  = base_r;
    rej_nxt   = 1'b0;
    ack_nxt   = 1'b0;
    data_nxt  = data_r;
    if (wrEn)
    begin
      // word 0 write also places the record; word 1 sits one word above
      if (wrAddr == base_r + `CTD_WORD_BYTES)
      begin
        // single flow must be set, reserved bits zero
        if (!wrData[`CTD_FLOW_BIT] || (wrData & `CTD_W1_MBZ_MASK) != 32'h0)
          rej_nxt = 1'b1;
        else
          word1_nxt = wrData;
      end
      else if ((wrData & `CTD_W0_MBZ_MASK) != 32'h0)
        rej_nxt = 1'b1;
      else
      begin
        // the block field already holds the number of whole 16-register blocks minus one
        word0_nxt = wrData;
        base_nxt  = wrAddr;
      end
    end
    if (link.rdReq && !ack_r)
    begin
      ack_nxt  = 1'b1;
      data_nxt = (link.rdAddr == base_r) ? word0_r : word1_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      word0_r <= 32'h0000_0000;
      word1_r <= 32'h8000_0000;
      base_r  <= 32'h0000_0000;
      ack_r   <= 1'b0;
      data_r  <= 32'h0000_0000;
      rej_r   <= 1'b0;
    end
    else
    begin
      word0_r <= word0_nxt;
      word1_r <= word1_nxt;
      base_r  <= base_nxt;
      ack_r   <= ack_nxt;
      data_r  <= data_nxt;
      rej_r   <= rej_nxt;
    end
  end

  assign link.rdAck  = ack_r;
  assign link.rdData = data_r;
  assign wrRejected  = rej_r;
endmodule

// ==== rtl/ctd_fetcher.sv ====
// device side: fetches the record on a pointer command and drives thread launch fields
`timescale 1ns/1ps
`include "ctd_consts.svh"
module ctd_fetcher
  import ctd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  ctd_link_if.fetcher      link,
  input  wire logic        ptrValid,
  input  wire logic [31:0] ptrAddr,
  input  wire logic [31:0] heapBase,
  output logic             busy,
  output logic             descValid,
  output logic [31:0]      kernelAddr,
  output logic [3:0]       blockCount,
  output logic [7:0]       regCount,
  output logic             singleFlow,
  output logic [7:0]       prefetchCount,
  output logic             highPriority,
  output logic             fpAltMode,
  output logic [15:0]      execCtrlWord
);
  typedef enum logic [1:0]
  {
    CTD_IDLE,
    CTD_RD0,
    CTD_RD1
  } ctd_state_t;

  ctd_state_t  st_r, st_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [31:0] w0_r, w0_nxt;
  ctd_desc_t   desc_r, desc_nxt;
  logic        valid_r, valid_nxt;
  logic [31:0] kaddr_r, kaddr_nxt;
  logic [3:0]  blocks_r, blocks_nxt;
  logic [7:0]  regs_r, regs_nxt;
  logic        req;
  logic        start;
  logic        done;
  ctd_desc_t   recDec;

  function automatic ctd_desc_t decode(input logic [31:0] w0, input logic [31:0] w1);
    ctd_desc_t d;
    d.kernelOffset   = w0[`CTD_KSP_HI:`CTD_KSP_LO];
    d.blocksMinusOne = w0[`CTD_BLK_HI:`CTD_BLK_LO];
    d.singleFlow     = w1[`CTD_FLOW_BIT];
    d.bindingCount   = w1[`CTD_BTC_HI:`CTD_BTC_LO];
    d.highPriority   = w1[`CTD_PRIO_BIT];
    d.fpMode         = ctd_fp_mode_t'(w1[`CTD_FPM_BIT]);
    d.illegalOpEn    = w1[`CTD_ILLOP_BIT];
    d.maskStackEn    = w1[`CTD_MSTK_BIT];
    return d;
  endfunction

  // field holds the block count minus one; eight blocks need a 4-bit result
  function automatic logic [3:0] block_count(input logic [2:0] m);
    return {1'b0, m} + 4'h1;
  endfunction

  // up to 128 registers, so the product needs eight bits
  function automatic logic [7:0] reg_count(input logic [2:0] m);
    return 8'(block_count(m)) * 8'(`CTD_REGS_PER_BLOCK);
  endfunction

  // 64-byte units from the heap base; upper bits beyond 32 wrap
  function automatic logic [31:0] kernel_addr(input logic [31:0] b, input logic [25:0] off);
    return b + {off, 6'h00};
  endfunction

  always_comb
  begin
    st_nxt    = st_r;
    addr_nxt  = addr_r;
    w0_nxt    = w0_r;
    req       = 1'b0;
    start     = 1'b0;
    done      = 1'b0;
    case (st_r)
      CTD_IDLE:
      begin
        if (ptrValid)
        begin
          addr_nxt  = ptrAddr;
          start     = 1'b1;
          st_nxt    = CTD_RD0;
        end
      end
      CTD_RD0:
      begin
        req = 1'b1;
        if (link.rdAck)
        begin
          w0_nxt   = link.rdData;
          addr_nxt = addr_r + `CTD_WORD_BYTES;
          st_nxt   = CTD_RD1;
        end
      end
      CTD_RD1:
      begin
        // gap cycle after an ack keeps one request per answer
        req = !link.rdAck;
        if (link.rdAck)
        begin
          done   = 1'b1;
          st_nxt = CTD_IDLE;
        end
      end
      default:
        st_nxt = CTD_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_r    <= CTD_IDLE;
      addr_r  <= 32'h0000_0000;
      w0_r    <= 32'h0000_0000;
    end
    else
    begin
      st_r    <= st_nxt;
      addr_r  <= addr_nxt;
      w0_r    <= w0_nxt;
    end
  end

  assign recDec = decode(w0_r, link.rdData);

  // launch fields; a half-fetched record never reaches the outputs
  always_comb
  begin
    desc_nxt   = desc_r;
    valid_nxt  = valid_r;
    kaddr_nxt  = kaddr_r;
    blocks_nxt = blocks_r;
    regs_nxt   = regs_r;
    if (start)
      valid_nxt = 1'b0;
    if (done)
    begin
      desc_nxt   = recDec;
      valid_nxt  = 1'b1;
      // heap base taken once per record; a later base change waits for a new pointer
      kaddr_nxt  = kernel_addr(heapBase, recDec.kernelOffset);
      blocks_nxt = block_count(recDec.blocksMinusOne);
      regs_nxt   = reg_count(recDec.blocksMinusOne);
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      desc_r   <= '0;
      valid_r  <= 1'b0;
      kaddr_r  <= 32'h0000_0000;
      blocks_r <= block_count(3'h0);
      regs_r   <= reg_count(3'h0);
    end
    else
    begin
      desc_r   <= desc_nxt;
      valid_r  <= valid_nxt;
      kaddr_r  <= kaddr_nxt;
      blocks_r <= blocks_nxt;
      regs_r   <= regs_nxt;
    end
  end

  assign link.rdReq    = req;
  assign link.rdAddr   = addr_r;
  assign busy          = (st_r != CTD_IDLE);
  assign descValid     = valid_r;
  assign kernelAddr    = kaddr_r;
  assign blockCount    = blocks_r;
  assign regCount      = regs_r;
  assign singleFlow    = desc_r.singleFlow;
  assign prefetchCount = desc_r.bindingCount;
  assign highPriority  = desc_r.highPriority;
  assign fpAltMode     = (desc_r.fpMode == CTD_FP_ALT);
  always_comb
  begin
    execCtrlWord = 16'h0000;
    execCtrlWord[`CTD_CR_ILLOP_BIT] = desc_r.illegalOpEn;
    execCtrlWord[`CTD_CR_MSTK_BIT]  = desc_r.maskStackEn;
  end
endmodule

// ==== bench/ctd_link_asserts.sv ====
// read link protocol checks for the descriptor fetch
`timescale 1ns/1ps
module ctd_link_asserts
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        rdReq,
  input wire logic [31:0] rdAddr,
  input wire logic        rdAck,
  input wire logic [31:0] rdData
);
  // tracks which record word is in flight, so pairing needs no view of busy
  logic        wordSel_r;
  logic        wordSel_nxt;
  logic [31:0] base_r;
  logic [31:0] base_nxt;
  always_comb
  begin
    wordSel_nxt = rdAck ? ~wordSel_r : wordSel_r;
    base_nxt    = (rdAck && !wordSel_r) ? rdAddr : base_r;
  end
  always_ff @(posedge clk)
  begin
    wordSel_r <= srst ? 1'b0 : wordSel_nxt;
    base_r    <= base_nxt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_word0; rdAck && !wordSel_r; endsequence
  sequence s_word1; ##[1:2] (rdReq && wordSel_r); endsequence
  property p_quiet; $fell(srst) |-> !rdReq && !rdAck; endproperty
  property p_ack_next; rdReq && !rdAck |=> rdAck; endproperty
  property p_addr_hold; rdReq && !rdAck |=> $stable(rdAddr); endproperty
  property p_ack_pulse; rdAck |=> !rdAck; endproperty
  property p_ack_cause; rdAck |-> $past(rdReq); endproperty
  property p_pair; s_word0 |-> s_word1; endproperty
  property p_second; rdReq && wordSel_r |-> rdAddr == base_r + 32'h0000_0004; endproperty
  property p_req_drop; rdAck && wordSel_r |=> !rdReq; endproperty
  a_quiet: assert property (p_quiet) else $error("link active after reset");
  a_ack_next: assert property (p_ack_next) else $error("read not answered");
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without read");
  a_pair: assert property (p_pair) else $error("second word not read");
  a_second: assert property (p_second) else $error("second word address");
  a_req_drop: assert property (p_req_drop) else $error("read after record");
endmodule

// ==== bench/tb.sv ====
// self-checking bench for the descriptor store and fetcher
`timescale 1ns/1ps
module tb;
  logic        clk, srst, wrEn, ptrValid, wrRejected, busy, descValid;
  logic        singleFlow, highPriority, fpAltMode;
  logic [31:0] wrAddr, wrData, ptrAddr, heapBase, kernelAddr, seed, w0, w1, base;
  logic [3:0]  blockCount;
  logic [7:0]  regCount;
  logic [31:0] d0, d1;
  logic [63:0] pend [$];
  logic [7:0]  prefetchCount;
  logic [15:0] execCtrlWord;
  int          checks, n_mismatch;
  logic [31:0] bad0 [3] = '{32'h0000_0001, 32'h0000_0010, 32'h0000_0020};
  logic [31:0] bad1 [8] = '{32'h0400_0000, 32'h0800_0000, 32'h1000_0000, 32'h2000_0000,
                            32'h4000_0000, 32'h0000_4000, 32'h0000_8000, 32'h0000_1000};
  ctd_link_if lnk();
  ctd_record_store u_ctd_record_store (.clk(clk), .srst(srst), .link(lnk), .wrEn(wrEn),
    .wrAddr(wrAddr), .wrData(wrData), .wrRejected(wrRejected));
  ctd_fetcher u_ctd_fetcher (.clk(clk), .srst(srst), .link(lnk), .ptrValid(ptrValid),
    .ptrAddr(ptrAddr), .heapBase(heapBase), .busy(busy), .descValid(descValid),
    .kernelAddr(kernelAddr), .blockCount(blockCount), .regCount(regCount),
    .singleFlow(singleFlow), .prefetchCount(prefetchCount), .highPriority(highPriority),
    .fpAltMode(fpAltMode), .execCtrlWord(execCtrlWord));
  ctd_link_asserts u_ctd_link_asserts (.clk(clk), .srst(srst), .rdReq(lnk.rdReq),
    .rdAddr(lnk.rdAddr), .rdAck(lnk.rdAck), .rdData(lnk.rdData));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic rej);
    @(posedge clk);
    wrEn <= 1'b1;
    wrAddr <= a;
    wrData <= d;
    @(posedge clk);
    wrEn <= 1'b0;
    #1 chk(wrRejected, rej);
  endtask
  task automatic fields();
    int bc;
    bc = w0[3:1] + 1;
    chk(kernelAddr, heapBase + {w0[31:6], 6'h00});
    chk(blockCount, bc);
    chk(regCount, bc * 16);
    chk(singleFlow, w1[31]);
    chk(prefetchCount, w1[25:18]);
    chk(highPriority, w1[17]);
    chk(fpAltMode, w1[16]);
    chk(execCtrlWord, {w1[13], w1[11]} << 11);
  endtask
  // a second pointer held into the busy cycle must be ignored
  task automatic fetch();
    int n;
    @(posedge clk);
    ptrValid <= 1'b1;
    ptrAddr <= base;
    heapBase <= rnd() & 32'h0000_FFFF;
    @(posedge clk);
    ptrAddr <= rnd();
    #1 chk(busy, 1'b1);
    chk(descValid, 1'b0);
    n = 0;
    do
    begin
      @(posedge clk);
      ptrValid <= 1'b0;
      #1 n++;
    end
    while (descValid !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_mismatch++;
      results();
    end
    // descValid rises four edges after the edge that takes the pointer
    chk(n, 4);
    {w1, w0} = pend.pop_front();
    fields();
  endtask
  initial
  begin
    srst = 1'b1;
    wrEn = 1'b0;
    ptrValid = 1'b0;
    wrAddr = '0;
    wrData = '0;
    ptrAddr = '0;
    heapBase = '0;
    seed = 32'h502D1D06;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    #1 chk(blockCount, 4'h1);
    chk(regCount, 8'h10);
    chk(descValid, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      base = rnd() & 32'h0FFF_FFF0;
      // bit 16 clear with a small heap base keeps every kernel below 4G
      d0 = rnd() & 32'hFFFE_FFCE | (i == 0 ? 32'h0000_000E : 32'h0);
      d1 = rnd() & 32'h83FF_2FFF | 32'h8000_0000;
      if (i == 1)
        d1 = d1 & 32'hFC03_FFFF;
      wr(base, d0, 1'b0);
      wr(base + 32'h4, d1, 1'b0);
      pend.push_back({d1, d0});
      if (i > 0)
        fields();
      wr(base, rnd() & 32'hFFFE_FFCE | bad0[i % 3], 1'b1);
      wr(base + 32'h4, d1 | bad1[i], 1'b1);
      wr(base + 32'h4, d1 & 32'h7FFF_FFFF, 1'b1);
      fetch();
    end
    results();
  end
endmodule
